//--- shared/lvic_defines.svh
// Purpose: constants for the low-voltage inhibit control block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: offsets are word aligned
`ifndef LVIC_DEFINES_SVH
`define LVIC_DEFINES_SVH
`define LVIC_ADDR_W 4
`define LVIC_OFF_STATUS 4'h0
`define LVIC_OFF_CONFIG 4'h4
`define LVIC_OFF_EVENT 4'h8
`define LVIC_OFF_MASK 4'hc
`define LVIC_CFG_PWRD 0
`define LVIC_CFG_RSTD 1
`define LVIC_CFG_STOP 2
`define LVIC_CFG_SEL5 3
`define LVIC_STAT_FLAG 0
`define LVIC_STAT_RST 1
`define LVIC_EV_FALL 0
`define LVIC_EV_RISE 1
`define LVIC_EV_RST 2
`define LVIC_CFG_RESET 4'h0
`define LVIC_EV_RESET 3'h0
`endif

//--- shared/lvic_pkg.sv
// Purpose: types for the low-voltage inhibit control block
// Assumes: lvic_defines.svh holds all numbers
// Notes: none
package lvic_pkg;
   typedef enum logic [1:0] {
      LVIC_RUN,
      LVIC_HOLD
   } lvic_mode_type;
   typedef struct packed {
      logic [1:0] fall_sync;
      logic [1:0] rise_sync;
      logic [3:0] cfg;
      logic flag;
      lvic_mode_type mode;
      logic [2:0] events;
      logic [2:0] mask;
      logic irq;
      logic ack;
      logic [31:0] dat;
      logic lv_reset;
      logic rst_pin_n;
      logic [3:0] pin_oe_n;
   } lvic_state_type;
endpackage

//--- hw/lvic_top.sv
// Purpose: low-voltage inhibit control with wishbone registers
// Assumes: comparator indications are asynchronous levels
// Notes: registers at 0x0 status, 0x4 config, 0x8 events, 0xc mask
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`include "lvic_defines.svh"
module lvic_top
   import lvic_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic por_i,
   input wire logic stop_mode_i,
   input wire logic wait_mode_i,
   input wire logic below_fall_i,
   input wire logic above_rise_i,
   input wire logic [`LVIC_ADDR_W-1:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic irq_o,
   output logic lowv_reset_o,
   output logic ext_rst_n_o,
   output logic ext_rst_oe_o,
   output logic monitor_on_o
);
   lvic_state_type cur;
   lvic_state_type nxt;
   logic mon_on;
   logic below;
   logic above;
   logic rst_en;
   logic wr;
   logic rd;
   logic [2:0] ev_set;
   logic [3:0] wcfg;

   always_comb begin
      nxt = cur;
      // stop mode gates the comparator unless stop-keep is set
      mon_on = !cur.cfg[`LVIC_CFG_PWRD] &&
         (!stop_mode_i || cur.cfg[`LVIC_CFG_STOP]);
      below = mon_on && cur.fall_sync[1];
      above = mon_on && cur.rise_sync[1];
      rst_en = !cur.cfg[`LVIC_CFG_RSTD];
      wr = cyc_i && stb_i && we_i && !cur.ack;
      rd = cyc_i && stb_i && !we_i && !cur.ack;
      ev_set = 3'h0;
      wcfg = cur.cfg;
      nxt.fall_sync = {cur.fall_sync[0], below_fall_i};
      nxt.rise_sync = {cur.rise_sync[0], above_rise_i};
      // flag tracks comparator with hysteresis between points
      if (below) begin
         nxt.flag = 1'b1;
         if (!cur.flag) ev_set[`LVIC_EV_FALL] = 1'b1;
      end else if (above) begin
         nxt.flag = 1'b0;
         if (cur.flag) ev_set[`LVIC_EV_RISE] = 1'b1;
      end
      unique case (cur.mode)
         LVIC_RUN: begin
            // polled mode: reset-disable blocks entry
            if (rst_en && below) begin
               nxt.mode = LVIC_HOLD;
               ev_set[`LVIC_EV_RST] = 1'b1;
            end
         end
         LVIC_HOLD: begin
            if (above) nxt.mode = LVIC_RUN;
         end
      endcase
      // write of 5V select while supply not above rising point
      if (wr && adr_i == `LVIC_OFF_CONFIG && sel_i[0])
         wcfg = dat_i[3:0];
      if (wr && adr_i == `LVIC_OFF_CONFIG && sel_i[0] &&
          wcfg[`LVIC_CFG_SEL5] && !cur.cfg[`LVIC_CFG_SEL5] &&
          !wcfg[`LVIC_CFG_PWRD] && !wcfg[`LVIC_CFG_RSTD] &&
          !cur.rise_sync[1]) begin
         nxt.mode = LVIC_HOLD;
         ev_set[`LVIC_EV_RST] = 1'b1;
      end
      nxt.cfg = wcfg;
      if (wr && adr_i == `LVIC_OFF_MASK && sel_i[0])
         nxt.mask = dat_i[2:0];
      // set wins over write-one-to-clear
      if (wr && adr_i == `LVIC_OFF_EVENT && sel_i[0])
         nxt.events = (cur.events & ~dat_i[2:0]) | ev_set;
      else
         nxt.events = cur.events | ev_set;
      nxt.irq = |(nxt.events & nxt.mask);
      nxt.ack = (wr || rd);
      nxt.dat = 32'h0;
      if (rd) begin
         unique case (adr_i)
            `LVIC_OFF_STATUS: begin
               nxt.dat[`LVIC_STAT_FLAG] = cur.flag;
               nxt.dat[`LVIC_STAT_RST] = (cur.mode == LVIC_HOLD);
            end
            `LVIC_OFF_CONFIG: nxt.dat[3:0] = cur.cfg;
            `LVIC_OFF_EVENT: nxt.dat[2:0] = cur.events;
            `LVIC_OFF_MASK: nxt.dat[2:0] = cur.mask;
            default: nxt.dat = 32'h0;
         endcase
      end
      // reset request also ends wait and stop outside this block
      nxt.lv_reset = (nxt.mode == LVIC_HOLD);
      nxt.rst_pin_n = !nxt.lv_reset;
      nxt.pin_oe_n = {4{!nxt.lv_reset}};
      if (wait_mode_i) nxt.pin_oe_n = cur.pin_oe_n;
      nxt.pin_oe_n = {4{!nxt.lv_reset}};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // power-on clears all; a plain reset keeps config and hold
         cur.fall_sync <= 2'h0;
         cur.rise_sync <= 2'h0;
         cur.flag <= 1'b0;
         cur.events <= `LVIC_EV_RESET;
         cur.mask <= 3'h0;
         cur.irq <= 1'b0;
         cur.ack <= 1'b0;
         cur.dat <= 32'h0;
         cur.pin_oe_n <= 4'hf;
         if (por_i) begin
            cur.cfg <= `LVIC_CFG_RESET;
            cur.mode <= LVIC_RUN;
            cur.lv_reset <= 1'b0;
            cur.rst_pin_n <= 1'b1;
         end
      end else if (ce_i) begin
         cur <= nxt;
      end
   end

   assign dat_o = cur.dat;
   assign ack_o = cur.ack;
   // only latched, masked events reach this line, including the monitor's fall and rise edges
   assign irq_o = cur.irq;
   assign lowv_reset_o = cur.lv_reset;
   assign ext_rst_n_o = cur.rst_pin_n;
   assign ext_rst_oe_o = !cur.pin_oe_n[0];
   assign monitor_on_o = !cur.cfg[`LVIC_CFG_PWRD];
endmodule

//--- dv/lvic_supply.sv
// Purpose: supply comparator pair facing lvic_top
// Assumes: lvl_i 0 low, 1 between trips, 2 high
// Notes: no comparator noise modelled
`timescale 1ns/10ps
module lvic_supply(
   input logic clk_i,
   input logic [1:0] lvl_i,
   output logic below_fall_o,
   output logic above_rise_o
);
   always_ff @(posedge clk_i) begin
      below_fall_o <= lvl_i == 2'h0;
      above_rise_o <= lvl_i == 2'h2;
   end
endmodule

//--- dv/lvic_top_asserts.sv
// Purpose: port checker for lvic_top
// Assumes: every reset is a power-on reset
// Notes: cfg shadows bus writes; latency slack of one edge
`timescale 1ns/10ps
module lvic_top_asserts(
   input logic clk_i,
   input logic rst_i,
   input logic below_fall_i,
   input logic above_rise_i,
   input logic [3:0] adr_i,
   input logic [31:0] dat_i,
   input logic we_i,
   input logic cyc_i,
   input logic [31:0] dat_o,
   input logic ack_o,
   input logic lowv_reset_o,
   input logic ext_rst_n_o,
   input logic ext_rst_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [3:0] cfg;
   wire wr = ack_o && we_i && adr_i == 4'h4;
   always_ff @(posedge clk_i) cfg <= rst_i ? 4'h0 : wr ? dat_i[3:0] : cfg;
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack long");
   ack_due_a: assert property (cyc_i && !ack_o |=> ack_o) else $error("no ack");
   data_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("dat");
   pin_low_a: assert property (
      lowv_reset_o |-> !ext_rst_n_o && ext_rst_oe_o) else $error("pin");
   hold_rise_a: assert property (
      $fell(lowv_reset_o) && !$past(rst_i) |-> $past(above_rise_i, 2))
      else $error("early release");
   fall_rst_a: assert property (
      below_fall_i [*3] ##0 cfg[1:0] == 2'h0 |-> ##[1:2] lowv_reset_o)
      else $error("no reset");
   no_reset_a: assert property (
      (cfg[0] || cfg[1]) && !lowv_reset_o |=> !lowv_reset_o)
      else $error("reset");
   sel_five_a: assert property (
      !above_rise_i [*3] ##0 wr && dat_i[3:0] == 4'h8 && cfg == 4'h0
      |-> ##[1:2] lowv_reset_o) else $error("no 5v reset");
   cover property (lowv_reset_o ##1 !lowv_reset_o);
   cover property (wr && dat_i[3]);
   cover property (ack_o && !we_i);
endmodule
bind lvic_top lvic_top_asserts chk (.*);

//--- dv/lvic_top_tb.sv
// Purpose: self-checking bench for lvic_top
// Assumes: por_i follows rst_i
// Notes: read data is checked from a queue by a monitor
`timescale 1ns/10ps
module lvic_top_tb;
   logic clk_i = 0;
   logic rst_i = 1;
   logic cyc_i = 0;
   logic we_i = 0;
   logic [1:0] lvl = 2'h2;
   logic [3:0] adr_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic [31:0] q[$];
   logic ack_o;
   logic irq_o;
   logic below_fall_i;
   logic above_rise_i;
   logic lowv_reset_o;
   logic ext_rst_n_o;
   logic monitor_on_o;
   int error_cnt = 0;
   int checks = 0;
   always #25 clk_i = ~clk_i;
   lvic_supply sup(.clk_i(clk_i), .lvl_i(lvl), .below_fall_o(below_fall_i),
      .above_rise_o(above_rise_i));
   lvic_top dut(.*, .ce_i(1'b1), .por_i(rst_i), .stop_mode_i(1'b0),
      .wait_mode_i(1'b0), .sel_i(4'hf), .stb_i(cyc_i), .ext_rst_oe_o());
   task complete_run;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %0t got %h exp %h", $time, s, e);
      end
   endtask
   // bounded wait: a silent slave ends the run
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1 && n < 9);
      if (n >= 9) begin
         error_cnt++;
         complete_run();
      end
      cyc_i <= 0;
      @(posedge clk_i);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      q.push_back(e);
      bus(0, a, 0);
   endtask
   task lv(input logic [1:0] v);
      lvl <= v;
      repeat (6) @(posedge clk_i);
   endtask
   task rst;
      rst_i <= 1;
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
   endtask
   always @(posedge clk_i) if (ack_o === 1 && !we_i) chk(dat_o, q.pop_front());
   initial begin
      void'($urandom(27630));
      rst();
      rd(4'h4, 0);
      rd(4'h0, 0);
      rd(4'h1, 0);
      lv(0);
      rd(4'h0, 3);
      chk({31'h0, lowv_reset_o}, 1);
      chk({31'h0, ext_rst_n_o}, 0);
      lv(1);
      rd(4'h0, 3);
      lv(2);
      rd(4'h0, 0);
      chk({31'h0, ext_rst_n_o}, 1);
      bus(1, 4'hc, 4);
      rd(4'h8, 7);
      chk({31'h0, irq_o}, 1);
      bus(1, 4'h8, 7);
      rd(4'h8, 0);
      chk({31'h0, irq_o}, 0);
      $display("test 1 done");
      bus(1, 4'h4, 2);
      lv(0);
      rd(4'h0, 1);
      lv(2);
      bus(1, 4'h4, 1);
      chk({31'h0, monitor_on_o}, 0);
      lv(0);
      rd(4'h0, 0);
      lv(1);
      bus(1, 4'h4, 0);
      bus(1, 4'h4, 8);
      rd(4'h0, 2);
      rd(4'h4, 8);
      lv(2);
      rd(4'h0, 0);
      rst();
      rd(4'h4, 0);
      chk({31'h0, monitor_on_o}, 1);
      chk({31'h0, lowv_reset_o}, 0);
      dat_i <= $urandom;
      @(posedge clk_i);
      bus(1, 4'hc, dat_i);
      rd(4'hc, dat_i & 32'h7);
      $display("test 2 done");
      complete_run();
   end
endmodule
